/* tspc_regs.vh */
// register offsets, field positions, reset values and timing figures of the touch sequencer
`ifndef TSPC_REGS_VH
`define TSPC_REGS_VH

// ==========================================================================
// register offsets
`define TSPC_OFS_PWR        10'h000
`define TSPC_OFS_CNT        10'h002
`define TSPC_OFS_THR        10'h003
`define TSPC_OFS_RECAL      10'h004
`define TSPC_OFS_RAW        10'h00B
`define TSPC_OFS_STATUS     10'h0F0
`define TSPC_OFS_CONN       10'h088
`define TSPC_OFS_ROUTE      10'h080
`define TSPC_OFS_RESULT     10'h0E0
`define TSPC_BANK_MSB       9
`define TSPC_BANK_LSB       3

// ==========================================================================
// field positions
`define TSPC_PWR_MODE       1:0
`define TSPC_PWR_WAKE       3:2
`define TSPC_PWR_LAST_HI    7
`define TSPC_PWR_LAST       6:4
`define TSPC_PWR_DEC        9:8
`define TSPC_CNT_FULL       7:4
`define TSPC_CNT_LOW        11:8
`define TSPC_THR_LVL        7:0
`define TSPC_THR_RATE       13:8
`define TSPC_RCL_FULL       9:0
`define TSPC_RCL_LOW        15:10

// ==========================================================================
// reset values and masks of writable bits
`define TSPC_RST_PWR        16'h0000
`define TSPC_RST_CNT        16'h0000
`define TSPC_RST_THR        16'h0000
`define TSPC_RST_RECAL      16'h0000
`define TSPC_RST_CONN       16'hFFFF
`define TSPC_RST_TYPE       2'b11
`define TSPC_MSK_PWR        16'h03FF
`define TSPC_MSK_CNT        16'h0FF0
`define TSPC_MSK_THR        16'h3FFF

// ==========================================================================
// power modes and per-pin route codes
`define TSPC_MODE_FULL      2'b00
`define TSPC_MODE_LOW       2'b10
`define TSPC_ROUTE_FLOAT    2'b00
`define TSPC_ROUTE_NEG      2'b01
`define TSPC_ROUTE_POS      2'b10
`define TSPC_ROUTE_BIAS     2'b11
`define TSPC_CONN_BAD       2'b00

// ==========================================================================
// timing figures in their own units
`define TSPC_CLK_NS         20
`define TSPC_STAGE_D64_NS   768000
`define TSPC_WAKE_STEP_MS   200
`define TSPC_NS_PER_MS      1000000
`define TSPC_STAGE_CYC      24'h00_9600
`define TSPC_WAKE_CYC       24'h98_9680

`endif

/* tspc_mem.v */
// small register file with one write port and registered read data
`timescale 1ns/1ps

module tspc_mem (
  input  wire        clock,    // system clock
  input  wire        wr_en,    // write strobe
  input  wire [2:0]  wr_addr,  // write word index
  input  wire [15:0] wr_data,  // write data
  input  wire [2:0]  rd_addr,  // read word index
  output reg  [15:0] rd_data   // read data, one cycle after address
);

  // ========================================================================
  // storage
  reg [15:0] mem_r [0:7];  // eight words

  // write and registered read
  always @(posedge clock) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end

endmodule

/* tspc_ctl.v */
// touch sequencer: stage timing, low power wake delay, input routing, proximity and recal control
`timescale 1ns/1ps
`include "tspc_regs.vh"

module tspc_ctl #(
  parameter [23:0] STAGE_CYC = `TSPC_STAGE_CYC, // stage cycles at rate 64
  parameter [23:0] WAKE_CYC  = `TSPC_WAKE_CYC   // one 200 ms step
) (
  input  wire        clock,          // 50 MHz system clock
  input  wire        sys_rst,        // synchronous reset, active high
  input  wire [9:0]  reg_addr,       // register address
  input  wire        reg_wr,         // write strobe, one cycle
  input  wire [15:0] reg_wdata,      // write data
  input  wire        reg_rd,         // read strobe, one cycle
  output reg  [15:0] reg_rdata,      // read data
  output reg         reg_rvalid,     // read data valid pulse
  input  wire [15:0] conv_data,      // converter result of current stage
  input  wire        ff_valid,       // fast filter words valid pulse
  input  wire [15:0] ff_word_one,    // fast filter word one
  input  wire [15:0] ff_word_three,  // fast filter word three
  input  wire [15:0] ff_average,     // fast filter average
  input  wire [15:0] ambient,        // stored ambient value
  output reg         conv_start,     // stage conversion start pulse
  output wire [2:0]  conv_stage,     // stage being converted
  output reg  [15:0] pin_route,      // two bits per sensor input pin
  output reg  [1:0]  conn_type,      // connection type of current stage
  output reg         conn_type_bad,  // connection type 00 selected
  output reg         seq_done,       // sequence finished pulse
  output wire        cal_enable,     // environmental calibration allowed
  output reg         force_recal     // forced recalibration pulse
);

  // ========================================================================
  // states and declarations
  localparam [1:0] ST_IDLE = 2'b00;  // stopped
  localparam [1:0] ST_CONV = 2'b01;  // converting stages
  localparam [1:0] ST_WAKE = 2'b10;  // low power delay

  reg  [15:0] pwr_r;         // power and sequence control
  reg  [15:0] cnt_r;         // proximity count control
  reg  [15:0] thr_r;         // proximity thresholds
  reg  [15:0] recal_r;       // recalibration times
  reg  [15:0] conn_r;        // connection types, two bits per stage
  reg  [15:0] raw_r;         // latest raw converter result
  reg  [1:0]  state_r;       // sequencer state
  reg  [2:0]  stage_r;       // current stage
  reg  [23:0] timer_r;       // stage or delay countdown
  reg  [1:0]  wake_left_r;   // delay steps still to run
  reg         prox1_r;       // comparator one flag
  reg         prox2_r;       // comparator two flag
  reg         seq_c1_r;      // comparator one seen this sequence
  reg         seq_c2_r;      // comparator two seen this sequence
  reg  [7:0]  hold_cnt_r;    // calibration hold sequences left
  reg  [9:0]  recal_cnt_r;   // sequences with comparator two set
  reg  [9:0]  rd_addr_r;     // address of pending read
  reg         rd_pend_r;     // read pending
  reg         route_seq_r;   // route memory output belongs to sequencer
  wire [15:0] route_q;       // route memory read data
  wire [15:0] result_q;      // result memory read data

  // ========================================================================
  // helpers
  // absolute difference of two codes
  function [15:0] abs_diff;
    input [15:0] a;
    input [15:0] b;
    begin
      abs_diff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // stage length in cycles for a decimation setting
  function [23:0] stage_len;
    input [1:0] dec;
    begin
      case (dec)
        2'b00:   stage_len = STAGE_CYC << 2;
        2'b01:   stage_len = STAGE_CYC << 1;
        default: stage_len = STAGE_CYC;
      endcase
    end
  endfunction

  // bank match of an address
  function in_bank;
    input [9:0] addr;
    input [9:0] base;
    begin
      in_bank = (addr[`TSPC_BANK_MSB:`TSPC_BANK_LSB] == base[`TSPC_BANK_MSB:`TSPC_BANK_LSB]);
    end
  endfunction

  // ========================================================================
  // decodes
  wire       mode_full = (pwr_r[`TSPC_PWR_MODE] == `TSPC_MODE_FULL); // full power
  wire       mode_low  = (pwr_r[`TSPC_PWR_MODE] == `TSPC_MODE_LOW);  // low power wake
  wire       mode_run  = mode_full | mode_low;                        // others shut down
  wire [2:0] seq_last  = pwr_r[`TSPC_PWR_LAST_HI] ? 3'h7 : pwr_r[`TSPC_PWR_LAST];
  wire       stage_end = (state_r == ST_CONV) && (timer_r <= 24'h00_0001);
  wire       seq_end   = stage_end && (stage_r == seq_last);
  wire       route_wr  = reg_wr && in_bank(reg_addr, `TSPC_OFS_ROUTE);
  wire       route_rd  = reg_rd && in_bank(reg_addr, `TSPC_OFS_ROUTE);
  wire [2:0] route_ra  = route_rd ? reg_addr[2:0] : stage_r; // host read takes the port

  assign conv_stage = stage_r;

  // ========================================================================
  // memories
  // per-stage pin routing, sixteen bits of two-bit pin fields
  tspc_mem u_route (
    .clock   (clock),
    .wr_en   (route_wr),
    .wr_addr (reg_addr[2:0]),
    .wr_data (reg_wdata),
    .rd_addr (route_ra),
    .rd_data (route_q)
  );

  // per-stage results for host position processing
  tspc_mem u_result (
    .clock   (clock),
    .wr_en   (stage_end),
    .wr_addr (stage_r),
    .wr_data (conv_data),
    .rd_addr (reg_addr[2:0]),
    .rd_data (result_q)
  );

  // ========================================================================
  // conversion sequencer
  // stages 0..last back to back, then restart, run the wake delay or stop when shut down
  always @(posedge clock) begin
    if (sys_rst) begin
      state_r     <= ST_IDLE;
      stage_r     <= 3'h0;
      timer_r     <= 24'h00_0000;
      wake_left_r <= 2'h0;
      conv_start  <= 1'b0;
      seq_done    <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      seq_done   <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (mode_run) begin
            state_r    <= ST_CONV;
            stage_r    <= 3'h0;
            timer_r    <= stage_len(pwr_r[`TSPC_PWR_DEC]);
            conv_start <= 1'b1;
          end
        end
        ST_CONV: begin
          if (!stage_end) begin
            timer_r <= timer_r - 24'h00_0001;
          end else if (stage_r != seq_last) begin
            // next stage with its own routing
            stage_r    <= stage_r + 3'h1;
            timer_r    <= stage_len(pwr_r[`TSPC_PWR_DEC]);
            conv_start <= 1'b1;
          end else begin
            seq_done <= 1'b1;
            stage_r  <= 3'h0;
            if (!mode_run) begin
              state_r <= ST_IDLE;
            end else if (mode_low) begin
              // delay follows the full conversion
              state_r     <= ST_WAKE;
              timer_r     <= WAKE_CYC;
              wake_left_r <= pwr_r[`TSPC_PWR_WAKE];
            end else begin
              timer_r    <= stage_len(pwr_r[`TSPC_PWR_DEC]);
              conv_start <= 1'b1;
            end
          end
        end
        ST_WAKE: begin
          if (!mode_run) begin
            state_r <= ST_IDLE;
          end else if (timer_r > 24'h00_0001) begin
            timer_r <= timer_r - 24'h00_0001;
          end else if (wake_left_r != 2'h0) begin
            // one more 200 ms step
            wake_left_r <= wake_left_r - 2'h1;
            timer_r     <= WAKE_CYC;
          end else begin
            // wake without host help
            state_r    <= ST_CONV;
            timer_r    <= stage_len(pwr_r[`TSPC_PWR_DEC]);
            conv_start <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // routing outputs
  // pin fields: 00 float, 01 negative, 10 positive, 11 bias; the polarity of
  // the converter terminal decides whether the code rises or falls
  always @(posedge clock) begin
    if (sys_rst) begin
      route_seq_r   <= 1'b0;
      pin_route     <= 16'hFFFF;
      conn_type     <= `TSPC_RST_TYPE;
      conn_type_bad <= 1'b0;
      raw_r         <= 16'h0000;
    end else begin
      route_seq_r <= !route_rd;
      if (route_seq_r) begin
        pin_route <= route_q;
      end
      conn_type     <= conn_r[{stage_r, 1'b0} +: 2];
      conn_type_bad <= (conn_r[{stage_r, 1'b0} +: 2] == `TSPC_CONN_BAD);
      if (stage_end) begin
        raw_r <= conv_data;
      end
    end
  end

  // ========================================================================
  // proximity comparators
  wire c1_hit = ff_valid && (abs_diff(ff_word_one, ff_word_three) >
                {6'h00, thr_r[`TSPC_THR_RATE], 4'h0});
  wire c2_hit = ff_valid && (abs_diff(ff_average, ambient) >
                {4'h0, thr_r[`TSPC_THR_LVL], 4'h0});
  wire prox_flag = prox1_r | prox2_r;
  wire seq_c2    = seq_c2_r | c2_hit;                  // comparator two this sequence

  // flags rise on any stage at once and fall only after a clean sequence
  always @(posedge clock) begin
    if (sys_rst) begin
      prox1_r  <= 1'b0;
      prox2_r  <= 1'b0;
      seq_c1_r <= 1'b0;
      seq_c2_r <= 1'b0;
    end else begin
      if (c1_hit) begin
        prox1_r <= 1'b1;
      end else if (seq_end) begin
        prox1_r <= seq_c1_r;
      end
      if (c2_hit) begin
        prox2_r <= 1'b1;
      end else if (seq_end) begin
        prox2_r <= seq_c2_r;
      end
      seq_c1_r <= seq_end ? 1'b0 : (seq_c1_r | c1_hit);
      seq_c2_r <= seq_end ? 1'b0 : (seq_c2_r | c2_hit);
    end
  end

  // ========================================================================
  // calibration hold
  // reload while proximity stands, count finished sequences once it clears
  wire [7:0] hold_load = mode_low ? {2'b00, cnt_r[`TSPC_CNT_LOW], 2'b00}
                                  : {cnt_r[`TSPC_CNT_FULL], 4'h0};
  always @(posedge clock) begin
    if (sys_rst) begin
      hold_cnt_r <= 8'h00;
    end else if (prox_flag) begin
      hold_cnt_r <= hold_load;
    end else if (seq_end && (hold_cnt_r != 8'h00)) begin
      hold_cnt_r <= hold_cnt_r - 8'h01;
    end
  end

  assign cal_enable = !prox_flag && (hold_cnt_r == 8'h00);

  // ========================================================================
  // forced recalibration
  // counts sequences in which comparator two stayed set
  wire [9:0] recal_lim = mode_low ? {4'h0, recal_r[`TSPC_RCL_LOW]} : recal_r[`TSPC_RCL_FULL];
  always @(posedge clock) begin
    if (sys_rst) begin
      recal_cnt_r <= 10'h000;
      force_recal <= 1'b0;
    end else begin
      force_recal <= 1'b0;
      if (seq_end) begin
        if (!seq_c2 || (recal_lim == 10'h000)) begin
          recal_cnt_r <= 10'h000;
        end else if ({1'b0, recal_cnt_r} + 11'h001 >= {1'b0, recal_lim}) begin
          recal_cnt_r <= 10'h000;
          force_recal <= 1'b1;
        end else begin
          recal_cnt_r <= recal_cnt_r + 10'h001;
        end
      end
    end
  end

  // ========================================================================
  // register writes
  always @(posedge clock) begin
    if (sys_rst) begin
      pwr_r   <= `TSPC_RST_PWR;
      cnt_r   <= `TSPC_RST_CNT;
      thr_r   <= `TSPC_RST_THR;
      recal_r <= `TSPC_RST_RECAL;
      conn_r  <= `TSPC_RST_CONN;
    end else if (reg_wr) begin
      case (reg_addr)
        `TSPC_OFS_PWR:   pwr_r   <= reg_wdata & `TSPC_MSK_PWR;
        `TSPC_OFS_CNT:   cnt_r   <= reg_wdata & `TSPC_MSK_CNT;
        `TSPC_OFS_THR:   thr_r   <= reg_wdata & `TSPC_MSK_THR;
        `TSPC_OFS_RECAL: recal_r <= reg_wdata;
        `TSPC_OFS_CONN:  conn_r  <= reg_wdata;
        default: begin
          // read-only, unmapped or route bank (written by u_route): ignored here
        end
      endcase
    end
  end

  // ========================================================================
  // register reads
  // address held one cycle while memories answer, data registered after
  always @(posedge clock) begin
    if (sys_rst) begin
      rd_addr_r  <= 10'h000;
      rd_pend_r  <= 1'b0;
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      rd_pend_r  <= reg_rd;
      reg_rvalid <= rd_pend_r;
      if (reg_rd) begin
        rd_addr_r <= reg_addr;
      end
      if (rd_pend_r) begin
        if (in_bank(rd_addr_r, `TSPC_OFS_ROUTE)) begin
          reg_rdata <= route_q;
        end else if (in_bank(rd_addr_r, `TSPC_OFS_RESULT)) begin
          reg_rdata <= result_q;
        end else begin
          case (rd_addr_r)
            `TSPC_OFS_PWR:    reg_rdata <= pwr_r;
            `TSPC_OFS_CNT:    reg_rdata <= cnt_r;
            `TSPC_OFS_THR:    reg_rdata <= thr_r;
            `TSPC_OFS_RECAL:  reg_rdata <= recal_r;
            `TSPC_OFS_CONN:   reg_rdata <= conn_r;
            `TSPC_OFS_RAW:    reg_rdata <= raw_r;
            `TSPC_OFS_STATUS: reg_rdata <= {7'h00, force_recal, cal_enable, prox2_r, prox1_r,
                                            state_r, stage_r};
            default:          reg_rdata <= 16'h0000;
          endcase
        end
      end
    end
  end

endmodule

/* tspc_ctl_assertions.sv */
// concurrent checks on the touch sequencer ports
`timescale 1ns/1ps
module tspc_chk #(
  parameter [23:0] WAKE_CYC = 24'h00_0014 // wake step cycles
) (
  input wire        clock,         // system clock
  input wire        sys_rst,       // sync reset
  input wire [9:0]  reg_addr,      // register address
  input wire        reg_wr,        // write strobe
  input wire [15:0] reg_wdata,     // write data
  input wire        reg_rd,        // read strobe
  input wire        reg_rvalid,    // read valid
  input wire        ff_valid,      // words valid
  input wire [15:0] ff_word_one,   // word one
  input wire [15:0] ff_word_three, // word three
  input wire [15:0] ff_average,    // average
  input wire [15:0] ambient,       // ambient
  input wire        conv_start,    // stage start
  input wire [2:0]  conv_stage,    // stage index
  input wire [1:0]  conn_type,     // connection type
  input wire        conn_type_bad, // bad type flag
  input wire        seq_done,      // sequence end
  input wire        cal_enable,    // calibration allowed
  input wire        force_recal    // forced recal
);
  // ==========
  // shadow copies of control registers
  reg [15:0] pwr_r;   // power control
  reg [15:0] thr_r;   // thresholds
  reg [15:0] rcl_r;   // recal times
  reg [31:0] since_r; // cycles since sequence end
  always @(posedge clock) begin
    if (sys_rst) begin
      pwr_r <= 16'h0000;
      thr_r <= 16'h0000;
      rcl_r <= 16'h0000;
      since_r <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == 10'h000) pwr_r <= reg_wdata;
      if (reg_wr && reg_addr == 10'h003) thr_r <= reg_wdata;
      if (reg_wr && reg_addr == 10'h004) rcl_r <= reg_wdata;
      since_r <= seq_done ? 32'h0 : since_r + 32'h1;
    end
  end
  // comparator inputs and mode dependent limits
  wire [15:0] d1 = (ff_word_one > ff_word_three) ? ff_word_one - ff_word_three
                                                 : ff_word_three - ff_word_one;
  wire [15:0] d2 = (ff_average > ambient) ? ff_average - ambient : ambient - ff_average;
  wire        hit1 = ff_valid && (d1 > {4'h0, thr_r[13:8], 4'h0});
  wire        hit2 = ff_valid && (d2 > {4'h0, thr_r[7:0], 4'h0});
  wire        low = (pwr_r[1:0] == 2'b10);
  wire [9:0]  rtm = low ? {4'h0, rcl_r[15:10]} : rcl_r[9:0];
  wire [31:0] wmin = ({30'h0, pwr_r[3:2]} + 32'h1) * {8'h00, WAKE_CYC};
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========
  // assertions
  chk_read_lat: assert property (reg_rd |-> ##2 reg_rvalid)
    else $error("read data valid late");
  chk_seq_wrap: assert property (seq_done && !pwr_r[1] && !pwr_r[0] && $stable(pwr_r)
    |-> conv_start && conv_stage == 3'h0) else $error("full mode gap");
  chk_stage_len: assert property (conv_start |=> !conv_start [*7])
    else $error("stage too short");
  chk_prox_one: assert property (hit1 |=> !cal_enable)
    else $error("approach did not stop calibration");
  chk_prox_two: assert property (hit2 |=> !cal_enable)
    else $error("hover did not stop calibration");
  chk_conn_flag: assert property (conn_type_bad == (conn_type == 2'b00))
    else $error("bad type flag wrong");
  chk_wake_gap: assert property (conv_start && conv_stage == 3'h0 && low
    |-> since_r + 32'h1 >= wmin && since_r <= wmin + 32'h8)
    else $error("wake delay wrong");
  chk_recal_time: assert property (force_recal |-> rtm != 10'h000)
    else $error("recal with zero time");
  chk_cal_rise: assert property ($rose(cal_enable) |-> seq_done || $past(seq_done))
    else $error("calibration back off sequence end");
  cov_seq: cover property (seq_done);
  cov_recal: cover property (force_recal);
  cov_cal_back: cover property ($rose(cal_enable));
endmodule
bind tspc_ctl tspc_chk #(.WAKE_CYC(WAKE_CYC)) u_chk (.clock(clock), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .ff_valid(ff_valid), .ff_word_one(ff_word_one),
  .ff_word_three(ff_word_three), .ff_average(ff_average), .ambient(ambient),
  .conv_start(conv_start), .conv_stage(conv_stage), .conn_type(conn_type),
  .conn_type_bad(conn_type_bad), .seq_done(seq_done), .cal_enable(cal_enable),
  .force_recal(force_recal));

/* tspc_fe_model.sv */
// front end model: converter codes and fast filter words
`timescale 1ns/1ps
module tspc_fe_model (
  input  wire        clock,         // system clock
  input  wire        seq_done,      // sequence end pulse
  input  wire [15:0] pin_route,     // routing of the stage
  input  wire [7:0]  touch,         // touched pins
  input  wire [15:0] w_one,         // next word one
  input  wire [15:0] w_three,       // next word three
  input  wire [15:0] w_avg,         // next average
  input  wire [15:0] w_amb,         // next ambient
  output reg  [15:0] conv_data,     // converter code
  output reg         ff_valid,      // words valid pulse
  output wire [15:0] ff_word_one,   // word one
  output wire [15:0] ff_word_three, // word three
  output wire [15:0] ff_average,    // average
  output wire [15:0] ambient        // ambient
);
  reg [63:0] hold_r; // words latched at sequence end
  integer    n;      // pin index
  initial ff_valid = 1'b0;
  // ==========
  // positive route raises the code, negative lowers it
  always @* begin
    conv_data = 16'h8000;
    for (n = 0; n < 8; n = n + 1) begin
      if (touch[n] && pin_route[2*n+:2] == 2'b10) conv_data = conv_data + 16'h0100;
      if (touch[n] && pin_route[2*n+:2] == 2'b01) conv_data = conv_data - 16'h0100;
    end
  end
  // words once per sequence, scrambled outside the pulse
  always @(posedge clock) begin
    ff_valid <= seq_done;
    if (seq_done) hold_r <= {w_one, w_three, w_avg, w_amb};
  end
  assign {ff_word_one, ff_word_three, ff_average, ambient} = ff_valid ? hold_r : ~hold_r;
endmodule

/* tb_top.sv */
// self-checking bench for the touch sequencer
`timescale 1ns/1ps
module tb_top;
  reg         clock, sys_rst, reg_wr, reg_rd; // clock, reset, strobes
  reg  [9:0]  reg_addr;                       // register address
  reg  [15:0] reg_wdata, t1, ta;              // write data, word stimulus
  reg  [7:0]  touch;                          // touched pins
  wire [15:0] reg_rdata, conv_data, pin_route, w1, w3, wa, wb; // data outputs
  wire        reg_rvalid, ff_valid, conv_start, seq_done, cal_enable, force_recal, bad;
  wire [2:0]  conv_stage; // stage index
  wire [1:0]  conn_type;  // connection type
  int         n_mismatch, n_compared, k, s, sd; // counters and loop indices
  logic [15:0] exp_q[$];  // pending read results
  logic [15:0] d, n, g;   // data, sequence count, cycle count
  localparam [39:0] reg_ofs = {10'h004, 10'h003, 10'h002, 10'h000};
  localparam [63:0] reg_msk = {16'hFFFF, 16'h3FFF, 16'h0FF0, 16'h03FF};
  tspc_ctl #(.STAGE_CYC(24'h00_0008), .WAKE_CYC(24'h00_0014)) dut (.clock(clock),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv_data(conv_data), .ff_valid(ff_valid), .ff_word_one(w1), .ff_word_three(w3),
    .ff_average(wa), .ambient(wb), .conv_start(conv_start), .conv_stage(conv_stage),
    .pin_route(pin_route), .conn_type(conn_type), .conn_type_bad(bad),
    .seq_done(seq_done), .cal_enable(cal_enable), .force_recal(force_recal));
  tspc_fe_model fe (.clock(clock), .seq_done(seq_done), .pin_route(pin_route),
    .touch(touch), .w_one(t1), .w_three(16'h1000), .w_avg(ta), .w_amb(16'h4000),
    .conv_data(conv_data), .ff_valid(ff_valid), .ff_word_one(w1), .ff_word_three(w3),
    .ff_average(wa), .ambient(wb));
  // ==========
  // compare, report and bus tasks
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("[FAIL] %0t reads never answered", $time);
    end
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = w;
    reg_rd = !w;
    if (!w) exp_q.push_back(v);
    @(negedge clock);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(negedge clock);
  endtask
  // bounded wait; counts sequence ends and cycles on the way
  task automatic wfor(input int kind, input logic [2:0] st);
    logic hit;
    hit = 1'b0;
    n = 16'h0000;
    g = 16'h0000;
    while (!hit && g < 16'h0FA0) begin
      @(negedge clock);
      g = g + 16'h0001;
      if (seq_done === 1'b1) n = n + 16'h0001;
      case (kind)
        0: hit = (seq_done === 1'b1);
        1: hit = (conv_start === 1'b1 && conv_stage === st);
        2: hit = (cal_enable === 1'b1);
        default: hit = (force_recal === 1'b1);
      endcase
    end
    if (!hit) begin
      n_mismatch++;
      $display("[FAIL] %0t wait ran out", $time);
      close_out;
    end
  endtask
  // read results leave in request order
  always @(posedge clock) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] %0t unrequested read", $time);
      end else cmp_rd(reg_rdata, exp_q.pop_front());
    end
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ==========
  // main sequence
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 28'h0};
    touch = 8'h03;
    t1 = 16'h1000;
    ta = 16'h4000;
    sd = $urandom(32'h0000_edd7);
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    for (k = 0; k < 4; k++) acc(1'b0, reg_ofs[10*k+:10], 16'h0000);
    acc(1'b0, 10'h088, 16'hFFFF);
    acc(1'b0, 10'h3FF, 16'h0000);
    for (k = 0; k < 4; k++) begin
      d = $urandom;
      if (k == 0) d = {d[15:10], 6'h21, d[3:2], 2'b00}; // full mode, two short stages
      acc(1'b1, reg_ofs[10*k+:10], d);
      acc(1'b0, reg_ofs[10*k+:10], d & reg_msk[16*k+:16]);
    end
    acc(1'b1, 10'h002, 16'h0010);
    acc(1'b1, 10'h003, 16'h0201);
    acc(1'b1, 10'h004, 16'h0003);
    acc(1'b1, 10'h080, 16'hFFFE);
    acc(1'b1, 10'h081, 16'hFFF7);
    acc(1'b1, 10'h00B, d);
    wfor(0, 3'h0);
    wfor(0, 3'h0);
    acc(1'b0, 10'h00B, 16'h7F00);
    acc(1'b0, 10'h0E0, 16'h8100);
    acc(1'b0, 10'h0E1, 16'h7F00);
    acc(1'b0, 10'h080, 16'hFFFE);
    for (k = 0; k < 4; k++) begin
      acc(1'b1, 10'h088, {12'hFFF, 2'b10, k[1:0]});
      for (s = 0; s < 2; s++) begin
        wfor(1, s[2:0]);
        repeat (4) @(negedge clock);
        cmp_val(pin_route, s ? 16'hFFF7 : 16'hFFFE);
        cmp_val({14'h0, conn_type}, s ? 16'h0002 : {14'h0, k[1:0]});
        cmp_val({15'h0, bad}, {15'h0, s == 0 && k == 0});
      end
    end
    wfor(0, 3'h0);
    t1 = 16'h1021;
    wfor(0, 3'h0);
    wfor(0, 3'h0);
    cmp_val({15'h0, cal_enable}, 16'h0000);
    t1 = 16'h1020;
    wfor(2, 3'h0);
    cmp_val(n, 16'h0011);
    wfor(0, 3'h0);
    ta = 16'h4011;
    wfor(3, 3'h0);
    cmp_val(n, 16'h0003);
    ta = 16'h4000;
    wfor(0, 3'h0);
    acc(1'b1, 10'h000, 16'h0216);
    wfor(0, 3'h0);
    wfor(1, 3'h0);
    cmp_val({15'h0, g >= 16'h0028 && g <= 16'h002E}, 16'h0001);
    repeat (8) @(negedge clock);
    close_out;
  end
endmodule
